// File: shared/cwo_pkg.sv
// package: kinds, carriers and helpers of the write ordering block
package cwo_pkg;

	localparam int CWO_LINE_W = 26;
	localparam int CWO_ID_W = 2;
	localparam int CWO_CNT_W = 4;

	typedef enum logic [3:0] {
		CWO_RD_UNIQUE, CWO_MK_UNIQUE, CWO_CL_UNIQUE,
		CWO_WR_UNIQUE, CWO_WR_LINE_UNIQUE,
		CWO_WR_BACK, CWO_WR_CLEAN, CWO_WR_EVICT, CWO_EVICT,
		CWO_WR_NO_SNOOP, CWO_OTHER
	} cwo_kind_e;

	typedef enum logic [2:0] {
		CWO_S_RD_ONCE, CWO_S_RD_CLEAN, CWO_S_RD_NSD, CWO_S_RD_SHARED,
		CWO_S_RD_UNIQUE, CWO_S_CL_INVALID, CWO_S_MK_INVALID,
		CWO_S_CL_SHARED
	} cwo_snp_e;

	typedef enum logic [1:0] {
		CWO_ACT_STORE, CWO_ACT_FULL, CWO_ACT_PART_WB, CWO_ACT_DROP
	} cwo_act_e;

	typedef logic [CWO_LINE_W-1:0] cwo_line_t;
	typedef logic [CWO_ID_W-1:0] cwo_id_t;

	typedef struct packed {
		cwo_kind_e kind;
		cwo_line_t line;
		logic partial;
		logic shareable;
		logic no_data;
		cwo_id_t id;
	} cwo_req_s;

	typedef struct packed {
		cwo_snp_e kind;
		cwo_line_t line;
		logic dirty;
	} cwo_snp_s;

	typedef struct packed {
		logic data;
		logic pass_dirty;
		logic inval;
	} cwo_rsp_s;

	typedef struct packed {
		cwo_kind_e kind;
		cwo_id_t id;
	} cwo_cmp_s;

	typedef struct packed {
		cwo_act_e code;
		cwo_line_t line;
	} cwo_act_s;

	typedef struct packed {
		logic used;
		logic lost;
		logic partial;
		logic refetch;
		cwo_kind_e kind;
		cwo_line_t line;
	} cwo_ent_s;

	// unique writes that need the ordering fence
	function automatic logic cwo_is_wu(cwo_kind_e k);
		return k == CWO_WR_UNIQUE || k == CWO_WR_LINE_UNIQUE;
	endfunction

	// writes that release or clean a cached line
	function automatic logic cwo_is_ev(cwo_kind_e k);
		return k == CWO_WR_BACK || k == CWO_WR_CLEAN ||
			k == CWO_WR_EVICT || k == CWO_EVICT;
	endfunction

	// coherent reads that are tracked until completion
	function automatic logic cwo_is_crd(cwo_kind_e k);
		return k == CWO_RD_UNIQUE || k == CWO_MK_UNIQUE ||
			k == CWO_CL_UNIQUE;
	endfunction

	// snoops that force the local copy invalid
	function automatic logic cwo_is_inval(cwo_snp_e k);
		return k == CWO_S_RD_UNIQUE || k == CWO_S_CL_INVALID ||
			k == CWO_S_MK_INVALID;
	endfunction

endpackage

// File: hw/cwo_count.sv
// outstanding transaction counter
`timescale 1ns/1ps
`default_nettype none
module cwo_count import cwo_pkg::*; #(
	parameter int W = CWO_CNT_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	// issue and completion events
	input wire logic inc,
	input wire logic dec,
	// nothing outstanding
	output logic zero
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} cwo_cnt_s;

	cwo_cnt_s st;
	cwo_cnt_s next_st;

	// up on issue, down on completion
	always_comb begin
		next_st = st;
		if (inc && !dec) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (dec && !inc) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign zero = (st.cnt == '0);
endmodule // cwo_count
`default_nettype wire

// File: hw/cwo_track.sv
// tracker of outstanding coherent reads and lost lines
`timescale 1ns/1ps
`default_nettype none
module cwo_track import cwo_pkg::*; #(
	parameter int N = 1 << CWO_ID_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	// allocation
	input wire logic alloc,
	input wire cwo_kind_e alloc_kind,
	input wire cwo_line_t alloc_line,
	input wire logic alloc_partial,
	output logic free_any,
	output cwo_id_t free_id,
	// invalidating snoop
	input wire logic hit_v,
	input wire cwo_line_t hit_line,
	// completion lookup
	input wire cwo_id_t look_id,
	output cwo_ent_s look,
	input wire logic rel,
	input wire logic rf_set,
	// refetch queue
	output logic rf_any,
	output cwo_id_t rf_id,
	output cwo_line_t rf_line,
	input wire logic rf_take
);
	typedef struct packed {
		cwo_ent_s [N-1:0] e;
	} cwo_trk_s;

	cwo_trk_s st;
	cwo_trk_s next_st;
	logic [N-1:0] hit;

	// per entry snoop match, including a line allocated this cycle
	for (genvar i = 0; i < N; i++) begin : g_hit
		assign hit[i] = hit_v && ((st.e[i].used &&
			st.e[i].line == hit_line) || (alloc &&
			free_id == cwo_id_t'(i) && alloc_line == hit_line));
	end

	// allocate, retarget, release; a snoop hit wins over any clear
	always_comb begin
		next_st = st;
		free_any = 1'b0;
		free_id = '0;
		rf_any = 1'b0;
		rf_id = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (!st.e[i].used) begin
				free_any = 1'b1;
				free_id = cwo_id_t'(i);
			end
			if (st.e[i].refetch) begin
				rf_any = 1'b1;
				rf_id = cwo_id_t'(i);
			end
		end
		if (rel) begin
			next_st.e[look_id].used = 1'b0;
		end
		if (rf_set) begin
			next_st.e[look_id].refetch = 1'b1;
			next_st.e[look_id].kind = CWO_RD_UNIQUE;
			next_st.e[look_id].lost = 1'b0;
		end
		if (rf_take) begin
			next_st.e[rf_id].refetch = 1'b0;
		end
		if (alloc) begin
			next_st.e[free_id].used = 1'b1;
			next_st.e[free_id].lost = 1'b0;
			next_st.e[free_id].refetch = 1'b0;
			next_st.e[free_id].partial = alloc_partial;
			next_st.e[free_id].kind = alloc_kind;
			next_st.e[free_id].line = alloc_line;
		end
		for (int i = 0; i < N; i++) begin
			if (hit[i]) begin
				next_st.e[i].lost = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign look = st.e[look_id];
	assign rf_line = st.e[rf_id].line;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// a matching invalidating snoop marks the entry lost
	AST_TRK_LOST: assert property (
		hit[look_id] && ce && !rel && !rf_set |=> st.e[$past(look_id)].lost)
		else $error("invalidating snoop not recorded");
endmodule // cwo_track
`default_nettype wire

// File: hw/cwo_main.sv
// coherent write ordering and overlapping store handling
`timescale 1ns/1ps
`default_nettype none
module cwo_main import cwo_pkg::*; #(
	parameter int CNT_W = CWO_CNT_W,
	parameter int TRK_N = 1 << CWO_ID_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic ce,
	// configuration straps
	input wire logic cfg_snoop_filter,
	input wire logic cfg_snoop_data,
	input wire logic cfg_no_dirty,
	input wire logic cfg_ru_for_partial,
	input wire logic cfg_partial_wb,
	// requests from the cache
	input wire logic req_valid,
	input wire cwo_req_s req,
	output logic req_ready,
	output logic req_err,
	// issue towards the interconnect
	output logic iss_valid,
	output cwo_req_s iss,
	input wire logic iss_ready,
	// completions from the interconnect
	input wire logic cmp_valid,
	input wire cwo_cmp_s cmp,
	// snoop port
	input wire logic snp_valid,
	input wire cwo_snp_s snp,
	output logic snp_ready,
	output logic rsp_valid,
	output cwo_rsp_s rsp,
	output logic inv_valid,
	output cwo_line_t inv_line,
	// actions back to the cache
	output logic act_valid,
	output cwo_act_s act
);
	typedef struct packed {
		logic req_ready;
		logic pend_v;
		cwo_req_s pend;
		logic iss_valid;
		cwo_req_s iss;
		logic err;
		logic snp_ready;
		logic rsp_valid;
		cwo_rsp_s rsp;
		logic inv_p;
		cwo_line_t inv_pl;
		logic inv_valid;
		cwo_line_t inv_line;
		logic act_valid;
		cwo_act_s act;
	} cwo_main_s;

	cwo_main_s st;
	cwo_main_s next_st;

	logic iss_fire;
	logic snp_fire;
	logic cmp_rd;
	logic wu_cap;
	logic wu_zero;
	logic ev_zero;
	logic go;
	logic refuse;
	logic alloc;
	logic rel;
	logic rf_set;
	logic rf_take;
	logic free_any;
	logic rf_any;
	cwo_id_t free_id;
	cwo_id_t rf_id;
	cwo_line_t rf_line;
	cwo_ent_s te;
	cwo_req_s cand;

	// handshakes and write capability
	assign iss_fire = st.iss_valid && iss_ready;
	assign snp_fire = snp_valid && st.snp_ready;
	assign cmp_rd = cmp_valid && cwo_is_crd(cmp.kind);
	assign wu_cap = cfg_no_dirty || cfg_snoop_data;

	// unique writes in flight
	cwo_count #(
		.W(CNT_W)
	) u_wu_cnt (
		.core_clk(core_clk),
		.reset(reset),
		.ce(ce),
		.inc(iss_fire && cwo_is_wu(st.iss.kind)),
		.dec(cmp_valid && cwo_is_wu(cmp.kind)),
		.zero(wu_zero)
	);

	// writebacks, cleans and evicts in flight
	cwo_count #(
		.W(CNT_W)
	) u_ev_cnt (
		.core_clk(core_clk),
		.reset(reset),
		.ce(ce),
		.inc(iss_fire && cwo_is_ev(st.iss.kind)),
		.dec(cmp_valid && cwo_is_ev(cmp.kind)),
		.zero(ev_zero)
	);

	// coherent read tracker
	cwo_track #(
		.N(TRK_N)
	) u_track (
		.core_clk(core_clk),
		.reset(reset),
		.ce(ce),
		.alloc(alloc),
		.alloc_kind(cand.kind),
		.alloc_line(cand.line),
		.alloc_partial(cand.partial),
		.free_any(free_any),
		.free_id(free_id),
		.hit_v(snp_fire && cwo_is_inval(snp.kind)),
		.hit_line(snp.line),
		.look_id(cmp.id),
		.look(te),
		.rel(rel),
		.rf_set(rf_set),
		.rf_any(rf_any),
		.rf_id(rf_id),
		.rf_line(rf_line),
		.rf_take(rf_take)
	);

	// request as it would be issued: CWO_EVICT loses its data, partial
	// clean unique may become read unique
	always_comb begin
		cand = st.pend;
		cand.id = free_id;
		if (st.pend.kind == CWO_EVICT) begin
			cand.no_data = 1'b1;
		end
		if (st.pend.kind == CWO_CL_UNIQUE && st.pend.partial &&
			cfg_ru_for_partial) begin
			cand.kind = CWO_RD_UNIQUE;
		end
	end

	// ordering fence on the held request
	always_comb begin
		go = 1'b0;
		refuse = 1'b0;
		if (cwo_is_wu(st.pend.kind)) begin
			refuse = !wu_cap;
			go = wu_cap && ev_zero;
		end else if (st.pend.kind == CWO_EVICT) begin
			refuse = !st.pend.shareable;
			go = st.pend.shareable && wu_zero && !cmp_rd;
		end else if (cwo_is_ev(st.pend.kind)) begin
			go = wu_zero;
		end else if (st.pend.kind == CWO_WR_NO_SNOOP) begin
			go = wu_zero;
		end else if (cwo_is_crd(st.pend.kind)) begin
			go = free_any;
		end else begin
			go = 1'b1;
		end
		if (!st.pend_v || st.iss_valid || rf_any) begin
			go = 1'b0;
			refuse = 1'b0;
		end
	end

	assign alloc = go && cwo_is_crd(cand.kind) && ce;
	assign rf_take = rf_any && !st.iss_valid && ce;

	// completion of a tracked read
	always_comb begin
		rel = 1'b0;
		rf_set = 1'b0;
		if (cmp_rd && ce) begin
			rel = !(te.kind == CWO_CL_UNIQUE && te.partial && te.lost);
			rf_set = !rel;
		end
	end

	// next state
	always_comb begin
		next_st = st;
		next_st.err = 1'b0;
		next_st.rsp_valid = 1'b0;
		next_st.act_valid = 1'b0;
		next_st.snp_ready = 1'b1;
		if (iss_fire) begin
			next_st.iss_valid = 1'b0;
		end
		// snoop answer, independent of any write path state
		if (snp_fire) begin
			next_st.rsp_valid = 1'b1;
			next_st.rsp.data = snp.dirty && cfg_snoop_data;
			next_st.rsp.pass_dirty = snp.dirty;
			next_st.rsp.inval = cwo_is_inval(snp.kind);
		end
		// invalidate one cycle after the answer
		next_st.inv_p = snp_fire && cwo_is_inval(snp.kind);
		next_st.inv_pl = snp.line;
		next_st.inv_valid = st.inv_p;
		next_st.inv_line = st.inv_pl;
		// action for a completed coherent read
		if (cmp_rd) begin
			next_st.act_valid = 1'b1;
			next_st.act.line = te.line;
			next_st.act.code = CWO_ACT_STORE;
			if (te.kind == CWO_MK_UNIQUE) begin
				next_st.act.code = CWO_ACT_FULL;
			end else if (te.kind == CWO_CL_UNIQUE) begin
				if (!te.partial) begin
					next_st.act.code = CWO_ACT_FULL;
				end else if (te.lost) begin
					next_st.act_valid = 1'b0;
				end else if (cfg_partial_wb) begin
					next_st.act.code = CWO_ACT_PART_WB;
				end
			end
		end
		// refetch of a lost line goes first
		if (rf_any && !st.iss_valid) begin
			next_st.iss_valid = 1'b1;
			next_st.iss.kind = CWO_RD_UNIQUE;
			next_st.iss.line = rf_line;
			next_st.iss.partial = 1'b1;
			next_st.iss.shareable = 1'b1;
			next_st.iss.no_data = 1'b0;
			next_st.iss.id = rf_id;
		end
		// held request: refuse, drop or issue
		if (refuse) begin
			next_st.pend_v = 1'b0;
			next_st.err = 1'b1;
		end else if (go) begin
			next_st.pend_v = 1'b0;
			if (st.pend.kind == CWO_EVICT) begin
				next_st.act_valid = 1'b1;
				next_st.act.code = CWO_ACT_DROP;
				next_st.act.line = st.pend.line;
			end
			if (st.pend.kind != CWO_EVICT || cfg_snoop_filter) begin
				next_st.iss_valid = 1'b1;
				next_st.iss = cand;
			end
		end
		// take a new request into the holding slot
		if (req_valid && st.req_ready) begin
			next_st.pend_v = 1'b1;
			next_st.pend = req;
		end
		next_st.req_ready = !next_st.pend_v;
	end

	// state register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// outputs straight from state
	assign req_ready = st.req_ready;
	assign req_err = st.err;
	assign iss_valid = st.iss_valid;
	assign iss = st.iss;
	assign snp_ready = st.snp_ready;
	assign rsp_valid = st.rsp_valid;
	assign rsp = st.rsp;
	assign inv_valid = st.inv_valid;
	assign inv_line = st.inv_line;
	assign act_valid = st.act_valid;
	assign act = st.act;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_snp_take;
		snp_valid && snp_ready && ce;
	endsequence

	sequence s_inval_take;
		s_snp_take ##0 cwo_is_inval(snp.kind);
	endsequence

	AST_WU_AFTER_EV: assert property (
		iss_valid && cwo_is_wu(iss.kind) |-> ev_zero)
		else $error("unique write issued with evicts pending");
	AST_EV_AFTER_WU: assert property (
		iss_valid && cwo_is_ev(iss.kind) |-> wu_zero)
		else $error("evict class issued with unique write pending");
	AST_SNP_READY: assert property (
		$past(ce) && !$past(reset) |-> snp_ready)
		else $error("snoop port not ready");
	AST_SNP_RSP: assert property (
		s_snp_take |=> rsp_valid && rsp.inval == $past(cwo_is_inval(snp.kind)))
		else $error("snoop not answered next cycle");
	AST_SNP_WHILE_WU: assert property (
		s_snp_take ##0 !wu_zero |=> rsp_valid)
		else $error("snoop stalled behind unique write");
	AST_RSP_DATA: assert property (
		s_snp_take ##0 snp.dirty |=> rsp.data == $past(cfg_snoop_data))
		else $error("snoop data flag wrong");
	AST_WU_CAP: assert property (
		iss_valid && cwo_is_wu(iss.kind) |-> cfg_no_dirty || cfg_snoop_data)
		else $error("unique write without snoop capability");
	AST_EVICT_FORM: assert property (
		iss_valid && iss.kind == CWO_EVICT |-> iss.no_data && iss.shareable)
		else $error("evict badly formed");
	AST_EVICT_SF: assert property (
		iss_valid && iss.kind == CWO_EVICT |-> cfg_snoop_filter)
		else $error("evict without snoop filter");
	AST_INV_STEP: assert property (
		s_inval_take ##1 ce |=> inv_valid && inv_line == $past(snp.line, 2))
		else $error("invalidate not one cycle after answer");
	AST_REFETCH: assert property (
		cmp_rd && ce && te.kind == CWO_CL_UNIQUE && te.partial && te.lost
		|=> !act_valid ##0 rf_any)
		else $error("lost partial clean unique stored");
	AST_FULL_CU: assert property (
		cmp_rd && ce && te.kind == CWO_CL_UNIQUE && !te.partial
		|=> act_valid && act.code == CWO_ACT_FULL)
		else $error("full line clean unique not stored");
endmodule // cwo_main
`default_nettype wire

// File: verif/cwo_icn_model.sv
// interconnect stand-in: takes issues, returns completions in order
`timescale 1ns/1ps
`default_nettype none
module cwo_icn_model import cwo_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// bench controls: withhold completions, slow acceptance
	input wire logic hold,
	input wire logic slow,
	// issue channel
	input wire logic iss_valid,
	input wire cwo_req_s iss,
	output logic iss_ready,
	// completion channel
	output logic cmp_valid,
	output cwo_cmp_s cmp
);
	cwo_cmp_s pend_q[$];
	logic [1:0] phase;

	// queue issues by arrival; complete one per cycle unless held
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pend_q.delete();
			phase <= 2'h0;
			iss_ready <= 1'b0;
			cmp_valid <= 1'b0;
			cmp <= '0;
		end else begin
			phase <= phase + 2'h1;
			iss_ready <= !slow || phase == 2'h3;
			if (iss_valid && iss_ready) begin
				pend_q.push_back('{iss.kind, iss.id});
			end
			if (!hold && pend_q.size() > 0) begin
				cmp_valid <= 1'b1;
				cmp <= pend_q.pop_front();
			end else begin
				cmp_valid <= 1'b0;
				cmp <= ~cmp; // idle lines keep moving
			end
		end
	end
endmodule // cwo_icn_model
`default_nettype wire

// File: verif/cwo_main_tb.sv
// bench of the write ordering block against an interconnect stand-in
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
$display("Error at %0t: got %0h exp %0h", $time, (g), (e)); end end
module cwo_main_tb import cwo_pkg::*;;
	// stimulus and bench state
	logic core_clk = 1'b0, reset = 1'b1, ce = 1'b1, hold = 1'b0, slow = 1'b0;
	logic cfg_snoop_filter = 1'b1, cfg_snoop_data = 1'b1, cfg_no_dirty = 1'b1;
	logic cfg_ru_for_partial = 1'b0, cfg_partial_wb = 1'b0;
	logic req_valid = 1'b0, snp_valid = 1'b0;
	cwo_req_s req = '0;
	cwo_snp_s snp = '0;
	cwo_line_t cur = '0;
	int error_cnt = 0, checked = 0, cyc = 0, errs = 0;
	cwo_req_s iss_q[$];
	cwo_act_s act_q[$];
	// design and stand-in outputs
	logic req_ready, req_err, iss_valid, iss_ready, cmp_valid;
	logic snp_ready, rsp_valid, inv_valid, act_valid;
	cwo_req_s iss;
	cwo_cmp_s cmp;
	cwo_rsp_s rsp;
	cwo_line_t inv_line;
	cwo_act_s act;

	cwo_main i_cwo_main (.core_clk, .reset, .ce, .cfg_snoop_filter,
		.cfg_snoop_data, .cfg_no_dirty, .cfg_ru_for_partial, .cfg_partial_wb,
		.req_valid, .req, .req_ready, .req_err, .iss_valid, .iss, .iss_ready,
		.cmp_valid, .cmp, .snp_valid, .snp, .snp_ready, .rsp_valid, .rsp,
		.inv_valid, .inv_line, .act_valid, .act);
	cwo_icn_model i_cwo_icn_model (.core_clk, .reset, .hold, .slow,
		.iss_valid, .iss, .iss_ready, .cmp_valid, .cmp);

	// 100 MHz clock
	initial forever #5 core_clk = ~core_clk;

	// record issues, actions and refusals; cut a hang short
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (!reset && iss_valid && iss_ready) iss_q.push_back(iss);
		if (!reset && act_valid) act_q.push_back(act);
		if (!reset && req_err) errs++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end

	// counts and verdict
	task automatic summarize;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// hand one request over, held until the slot takes it
	task automatic send(cwo_kind_e k, logic p, logic s);
		int n;
		n = 0;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{k, cur, p, s, k == CWO_EVICT, 2'h0};
		do begin
			@(posedge core_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 60);
		req_valid <= 1'b0;
		req <= ~req;
	endtask

	// look for an issue of kind k within n cycles
	task automatic wait_iss(cwo_kind_e k, int n, output cwo_req_s r,
		output bit f);
		f = 1'b0;
		for (int i = 0; i < n && !f; i++) begin
			@(posedge core_clk) #1;
			while (iss_q.size() > 0 && !f) begin
				r = iss_q.pop_front();
				f = r.kind === k;
			end
		end
	endtask

	// expect exactly one action of code c on the current line
	task automatic wait_act(cwo_act_e c);
		for (int i = 0; i < 60 && act_q.size() == 0; i++) begin
			@(posedge core_clk) #1;
		end
		`CHK(act_q.size(), 1)
		if (act_q.size() > 0) begin
			`CHK(act_q[0].code, c)
			`CHK(act_q[0].line, cur)
		end
		act_q.delete();
	endtask

	// one snoop on the current line; answer next cycle, invalidate after
	task automatic snoop(cwo_snp_e k, logic d, logic inv);
		@(posedge core_clk);
		snp_valid <= 1'b1;
		snp <= '{k, cur, d};
		@(posedge core_clk);
		snp_valid <= 1'b0;
		snp <= ~snp;
		#1;
		`CHK(rsp_valid, 1'b1)
		`CHK(rsp.data, d & cfg_snoop_data)
		`CHK(rsp.inval, inv)
		@(posedge core_clk);
		#1;
		`CHK(inv_valid, inv)
		if (inv) `CHK(inv_line, cur)
	endtask

	// fence both ways between unique writes and line releases
	task automatic t_fence;
		cwo_kind_e ev[5] = '{CWO_WR_BACK, CWO_WR_CLEAN, CWO_WR_EVICT,
			CWO_EVICT, CWO_WR_NO_SNOOP};
		cwo_kind_e wu;
		cwo_req_s r;
		bit f;
		slow <= 1'b1;
		foreach (ev[i]) begin
			wu = (i % 2) ? CWO_WR_LINE_UNIQUE : CWO_WR_UNIQUE;
			cur = cur + 26'h40;
			hold <= 1'b1;
			send(wu, 1'b0, 1'b1);
			wait_iss(wu, 30, r, f);
			`CHK(f, 1'b1)
			send(ev[i], 1'b0, 1'b1);
			wait_iss(ev[i], 20, r, f);
			`CHK(f, 1'b0)
			snoop(CWO_S_RD_SHARED, 1'b1, 1'b0);
			hold <= 1'b0;
			wait_iss(ev[i], 40, r, f);
			`CHK(f, 1'b1)
			if (ev[i] != CWO_WR_NO_SNOOP) begin
				hold <= 1'b1;
				send(ev[i], 1'b0, 1'b1);
				wait_iss(ev[i], 30, r, f);
				`CHK(f, 1'b1)
				send(wu, 1'b0, 1'b1);
				wait_iss(wu, 20, r, f);
				`CHK(f, 1'b0)
				hold <= 1'b0;
				wait_iss(wu, 40, r, f);
				`CHK(f, 1'b1)
			end
		end
		slow <= 1'b0;
	endtask

	// refusals: unique writes with unanswerable snoops, bad evicts
	task automatic t_refuse;
		cwo_req_s r;
		bit f;
		int e;
		cfg_snoop_data <= 1'b0;
		cfg_no_dirty <= 1'b0;
		e = errs;
		send(CWO_WR_UNIQUE, 1'b0, 1'b1);
		wait_iss(CWO_WR_UNIQUE, 12, r, f);
		`CHK(f, 1'b0)
		`CHK(errs - e, 1)
		snoop(CWO_S_RD_ONCE, 1'b1, 1'b0);
		cfg_no_dirty <= 1'b1;
		send(CWO_WR_LINE_UNIQUE, 1'b0, 1'b1);
		wait_iss(CWO_WR_LINE_UNIQUE, 20, r, f);
		`CHK(f, 1'b1)
		cfg_snoop_data <= 1'b1;
		send(CWO_EVICT, 1'b0, 1'b0);
		wait_iss(CWO_EVICT, 12, r, f);
		`CHK(f, 1'b0)
		`CHK(errs - e, 2)
		act_q.delete();
		cfg_snoop_filter <= 1'b0;
		send(CWO_EVICT, 1'b0, 1'b1);
		wait_iss(CWO_EVICT, 12, r, f);
		`CHK(f, 1'b0)
		wait_act(CWO_ACT_DROP);
		cfg_snoop_filter <= 1'b1;
		send(CWO_EVICT, 1'b0, 1'b1);
		wait_iss(CWO_EVICT, 20, r, f);
		`CHK(r.no_data, 1'b1)
		`CHK(r.shareable, 1'b1)
		wait_act(CWO_ACT_DROP);
	endtask

	// one tracked read with an optional invalidating snoop in flight
	task automatic ovl(cwo_kind_e k, int p, cwo_snp_e sk, int sn, int rf,
		cwo_act_e c);
		cwo_req_s r;
		bit f;
		cwo_kind_e ik;
		cur = cur + 26'h40;
		act_q.delete();
		hold <= 1'b1;
		send(k, p != 0, 1'b1);
		// strap value seen after the edge that took the request
		ik = (k == CWO_CL_UNIQUE && p != 0 && cfg_ru_for_partial) ?
			CWO_RD_UNIQUE : k;
		wait_iss(ik, 20, r, f);
		`CHK(f, 1'b1)
		`CHK(r.line, cur)
		if (sn != 0) begin
			snoop(sk, 1'b0, 1'b1);
		end
		hold <= 1'b0;
		if (rf != 0) begin
			wait_iss(CWO_RD_UNIQUE, 40, r, f);
			`CHK(f, 1'b1)
			`CHK(act_q.size(), 0)
		end
		wait_act(c);
	endtask

	// second-sequenced stores under the three configurations
	task automatic t_overlap;
		ovl(CWO_RD_UNIQUE, 0, CWO_S_CL_INVALID, 1, 0, CWO_ACT_STORE);
		ovl(CWO_MK_UNIQUE, 0, CWO_S_MK_INVALID, 1, 0, CWO_ACT_FULL);
		ovl(CWO_CL_UNIQUE, 0, CWO_S_RD_UNIQUE, 1, 0, CWO_ACT_FULL);
		ovl(CWO_CL_UNIQUE, 1, CWO_S_CL_INVALID, 1, 1, CWO_ACT_STORE);
		ovl(CWO_CL_UNIQUE, 1, CWO_S_RD_ONCE, 0, 0, CWO_ACT_STORE);
		cfg_partial_wb <= 1'b1;
		ovl(CWO_CL_UNIQUE, 1, CWO_S_RD_ONCE, 0, 0, CWO_ACT_PART_WB);
		cfg_ru_for_partial <= 1'b1;
		cfg_partial_wb <= 1'b0;
		ovl(CWO_CL_UNIQUE, 1, CWO_S_RD_ONCE, 0, 0, CWO_ACT_STORE);
		cfg_ru_for_partial <= 1'b0;
	endtask

	// clock enable low freezes all state; a held snoop is taken after
	task automatic t_freeze;
		@(posedge core_clk);
		ce <= 1'b0;
		snp_valid <= 1'b1;
		snp <= '{CWO_S_CL_INVALID, cur, 1'b1};
		repeat (3) @(posedge core_clk);
		#1;
		`CHK(rsp_valid, 1'b0)
		`CHK(req_ready, 1'b1)
		@(posedge core_clk);
		ce <= 1'b1;
		@(posedge core_clk);
		snp_valid <= 1'b0;
		#1;
		`CHK(rsp_valid, 1'b1)
		`CHK(rsp.pass_dirty, 1'b1)
		`CHK(rsp.inval, 1'b1)
		@(posedge core_clk);
		#1;
		`CHK(inv_valid, 1'b1)
	endtask

	// reset, then the scenarios in turn
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(snp_ready, 1'b1)
		`CHK(req_ready, 1'b1)
		t_fence();
		t_refuse();
		t_overlap();
		t_freeze();
		summarize();
	end
endmodule // cwo_main_tb
`default_nettype wire
